// *** rtl/rodbg_osc_counter.sv ***
`timescale 1ns/1ps
// One oscillator counter; counts on its own oscillator edge, no reset.
module rodbg_osc_counter
    import rodbg_pkg::*;
#(
    parameter int CNT_W = RODBG_CNT_W
) (
    // Oscillator domain
    input wire logic osc_clk,
    input wire logic osc_run,
    // Count
    output logic [CNT_W-1:0] count
);
    initial begin
        if (CNT_W < 1) begin
            $error("CNT_W must be positive");
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Deliberately no reset: value survives system reset; zero at power-up only
    logic [CNT_W-1:0] count_q = '0;

    always_ff @(posedge osc_clk) begin
        if (osc_run) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    assign count = count_q;
endmodule : rodbg_osc_counter

// *** rtl/rodbg_pkg.sv ***
package rodbg_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] RODBG_OFS_OSC_CTRL = 8'h06;
    localparam logic [7:0] RODBG_OFS_CORE_CELL = 8'h07;
    localparam logic [7:0] RODBG_OFS_CORE_WIRE = 8'h08;
    localparam logic [7:0] RODBG_OFS_PERIPH_CELL = 8'h09;
    localparam logic [7:0] RODBG_OFS_PERIPH_WIRE = 8'h0A;
    localparam logic [7:0] RODBG_OFS_RAM_SIZE = 8'h0C;
    localparam logic [7:0] RODBG_OFS_SAVED_STATUS = 8'h10;
    localparam logic [7:0] RODBG_OFS_SAVED_PC = 8'h11;
    localparam logic [7:0] RODBG_OFS_SAVED_SP = 8'h12;
    localparam logic [7:0] RODBG_OFS_THREAD_SEL = 8'h13;
    localparam logic [7:0] RODBG_OFS_REG_SEL = 8'h14;
    localparam logic [7:0] RODBG_OFS_IRQ_CAUSE = 8'h15;
    localparam logic [7:0] RODBG_OFS_IRQ_INFO = 8'h16;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int RODBG_CTRL_CORE_EN_BIT = 1;
    localparam int RODBG_CTRL_PERIPH_EN_BIT = 0;
    localparam int RODBG_CNT_W = 16;
    localparam int RODBG_RAM_LSB = 2;
    localparam int RODBG_SSR_W = 11;
    localparam logic [10:0] RODBG_SSR_WMASK = 11'h6DF;
    localparam logic [10:0] RODBG_SSR_VALID = 11'h7DF;
    localparam int RODBG_SSR_ISSUE_BIT = 8;
    localparam int RODBG_THREAD_W = 8;
    localparam int RODBG_REGNUM_W = 5;
    localparam int RODBG_CAUSE_CODE_LSB = 0;
    localparam int RODBG_CAUSE_THREAD_LSB = 8;
    localparam int RODBG_CAUSE_UNIT_LSB = 16;
    localparam int RODBG_UNITS = 4;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [1:0] RODBG_CTRL_RST = 2'h0;
    localparam logic [2:0] RODBG_CAUSE_RST = 3'h0;
    localparam int RODBG_STOP_SETTLE_CYC = 10;

    typedef enum logic [2:0] {
        RODBG_CAUSE_NONE = 3'h0,
        RODBG_CAUSE_HOST = 3'h1,
        RODBG_CAUSE_DEBUG_CALL_INSTR = 3'h2,
        RODBG_CAUSE_IBREAK = 3'h3,
        RODBG_CAUSE_DWATCH = 3'h4,
        RODBG_CAUSE_RWATCH = 3'h5
    } rodbg_cause_t;
endpackage : rodbg_pkg

// *** rtl/rodbg_regs.sv ***
`timescale 1ns/1ps
module rodbg_regs
    import rodbg_pkg::*;
#(
    parameter logic [31:0] RAM_BYTES = 32'h0008_0000,
    parameter int THREAD_W = RODBG_THREAD_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Ring oscillator clocks (free-running, asynchronous)
    input wire logic core_cell_osc_clk,
    input wire logic core_wire_osc_clk,
    input wire logic periph_cell_osc_clk,
    input wire logic periph_wire_osc_clk,
    // Oscillator run controls to the oscillator cells
    output logic core_osc_en,
    output logic periph_osc_en,
    // Status read and write instruction port
    input wire logic ps_wr,
    input wire logic ps_rd,
    input wire logic [7:0] ps_addr,
    input wire logic [31:0] ps_wdata,
    output logic [31:0] ps_rdata,
    output logic ps_hit,
    // Debugger entry capture
    input wire logic dbg_enter,
    input wire logic [RODBG_SSR_W-1:0] dbg_status_word,
    input wire logic [31:0] dbg_pc,
    input wire logic [31:0] dbg_sp,
    input wire logic [2:0] dbg_cause,
    input wire logic [THREAD_W-1:0] dbg_thread,
    input wire logic [RODBG_UNITS-1:0] dbg_unit_hits,
    input wire logic [31:0] dbg_info,
    // Selector outputs to the thread register read path
    output logic [THREAD_W-1:0] dbg_read_thread,
    output logic [RODBG_REGNUM_W-1:0] dbg_read_reg
);
    initial begin
        if (THREAD_W != RODBG_THREAD_W) begin
            $error("THREAD_W must be 8");
        end
        if (RAM_BYTES[1:0] != 2'h0) begin
            $error("RAM_BYTES must be a multiple of four");
        end
        if (RAM_BYTES == 32'h0) begin
            $error("RAM_BYTES must not be zero");
        end
        if (RODBG_UNITS != 4) begin
            $error("unit field holds four units only");
        end
        if (RODBG_CNT_W > 16) begin
            $error("count field is 16 bits wide");
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] lowest_unit(input logic [RODBG_UNITS-1:0] hits);
        lowest_unit = 2'h0;
        for (int i = RODBG_UNITS - 1; i >= 0; i--) begin
            if (hits[i]) begin
                lowest_unit = 2'(i);
            end
        end
    endfunction : lowest_unit

    function automatic logic wr_to(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
        wr_to = wr && (addr == ofs);
    endfunction : wr_to

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // Strobe and address passed in so the assigns re-evaluate on every change
    logic we_ctrl;
    logic we_ssr;
    logic we_spc;
    logic we_ssp;
    logic we_thr;
    logic we_reg;
    logic we_cause;
    logic we_info;

    assign we_ctrl = wr_to(ps_wr, ps_addr, RODBG_OFS_OSC_CTRL);
    assign we_ssr = wr_to(ps_wr, ps_addr, RODBG_OFS_SAVED_STATUS);
    assign we_spc = wr_to(ps_wr, ps_addr, RODBG_OFS_SAVED_PC);
    assign we_ssp = wr_to(ps_wr, ps_addr, RODBG_OFS_SAVED_SP);
    assign we_thr = wr_to(ps_wr, ps_addr, RODBG_OFS_THREAD_SEL);
    assign we_reg = wr_to(ps_wr, ps_addr, RODBG_OFS_REG_SEL);
    assign we_cause = wr_to(ps_wr, ps_addr, RODBG_OFS_IRQ_CAUSE);
    assign we_info = wr_to(ps_wr, ps_addr, RODBG_OFS_IRQ_INFO);

    // ----------------------------------------
    // Oscillator control
    // ----------------------------------------
    logic [1:0] osc_ctrl_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_ctrl_q <= RODBG_CTRL_RST;
        end else if (we_ctrl) begin
            osc_ctrl_q <= ps_wdata[1:0];
        end
    end

    assign core_osc_en = osc_ctrl_q[RODBG_CTRL_CORE_EN_BIT];
    assign periph_osc_en = osc_ctrl_q[RODBG_CTRL_PERIPH_EN_BIT];

    // ----------------------------------------
    // Oscillator counters
    // ----------------------------------------
    // Enable is not synchronised into the oscillator domain; the counts
    // are only trusted after the stop has settled, which software ensures.
    logic [3:0] osc_clks;
    logic [3:0] osc_runs;
    logic [RODBG_CNT_W-1:0] osc_count [4];

    assign osc_clks = {periph_wire_osc_clk, periph_cell_osc_clk, core_wire_osc_clk, core_cell_osc_clk};
    assign osc_runs = {periph_osc_en, periph_osc_en, core_osc_en, core_osc_en};

    generate
        for (genvar g = 0; g < 4; g++) begin : g_osc
            rodbg_osc_counter #(
                .CNT_W(RODBG_CNT_W)
            ) u_cnt (
                .osc_clk(osc_clks[g]),
                .osc_run(osc_runs[g]),
                .count(osc_count[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Debug state registers
    // ----------------------------------------
    logic [RODBG_SSR_W-1:0] ssr_q;
    logic [31:0] spc_q;
    logic [31:0] ssp_q;
    logic [THREAD_W-1:0] thr_sel_q;
    logic [RODBG_REGNUM_W-1:0] reg_sel_q;
    logic [2:0] cause_q;
    logic [THREAD_W-1:0] cause_thr_q;
    logic [1:0] cause_unit_q;
    logic [31:0] info_q;
    logic unit_cause;
    logic host_cause;
    logic info_cause;

    assign unit_cause = (dbg_cause == RODBG_CAUSE_IBREAK) || (dbg_cause == RODBG_CAUSE_DWATCH) ||
                        (dbg_cause == RODBG_CAUSE_RWATCH);
    assign host_cause = (dbg_cause == RODBG_CAUSE_HOST);
    assign info_cause = (dbg_cause == RODBG_CAUSE_DWATCH) || (dbg_cause == RODBG_CAUSE_RWATCH);

    // Capture wins over a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ssr_q <= '0;
        end else if (dbg_enter) begin
            ssr_q <= dbg_status_word & RODBG_SSR_VALID;
        end else if (we_ssr) begin
            // Issue-mode bit and bit 5 are read-only
            ssr_q <= (ps_wdata[10:0] & RODBG_SSR_WMASK) | (ssr_q & ~RODBG_SSR_WMASK);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            spc_q <= '0;
        end else if (dbg_enter) begin
            spc_q <= dbg_pc;
        end else if (we_spc) begin
            spc_q <= ps_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ssp_q <= '0;
        end else if (dbg_enter) begin
            ssp_q <= dbg_sp;
        end else if (we_ssp) begin
            ssp_q <= ps_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            thr_sel_q <= '0;
        end else if (we_thr) begin
            thr_sel_q <= ps_wdata[THREAD_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_sel_q <= '0;
        end else if (we_reg) begin
            reg_sel_q <= ps_wdata[RODBG_REGNUM_W-1:0];
        end
    end

    assign dbg_read_thread = thr_sel_q;
    assign dbg_read_reg = reg_sel_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cause_q <= RODBG_CAUSE_RST;
        end else if (dbg_enter) begin
            cause_q <= dbg_cause;
        end else if (we_cause) begin
            cause_q <= ps_wdata[RODBG_CAUSE_CODE_LSB +: 3];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cause_thr_q <= '0;
        end else if (dbg_enter) begin
            cause_thr_q <= host_cause ? '0 : dbg_thread;
        end else if (we_cause) begin
            cause_thr_q <= ps_wdata[RODBG_CAUSE_THREAD_LSB +: THREAD_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cause_unit_q <= 2'h0;
        end else if (dbg_enter) begin
            cause_unit_q <= unit_cause ? lowest_unit(dbg_unit_hits) : 2'h0;
        end else if (we_cause) begin
            cause_unit_q <= ps_wdata[RODBG_CAUSE_UNIT_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            info_q <= '0;
        end else if (dbg_enter && info_cause) begin
            info_q <= dbg_info;
        end else if (we_info) begin
            info_q <= ps_wdata;
        end
    end

    // ----------------------------------------
    // Read word assembly
    // ----------------------------------------
    // Reserved positions are built as zeros here so the read mux stays a plain select
    logic [31:0] ctrl_word;
    logic [31:0] ram_word;
    logic [31:0] ssr_word;
    logic [31:0] thr_word;
    logic [31:0] reg_word;
    logic [31:0] cause_word;
    logic [31:0] count_word [4];

    generate
        for (genvar g = 0; g < 4; g++) begin : g_cnt_word
            assign count_word[g] = {{(32 - RODBG_CNT_W){1'b0}}, osc_count[g]};
        end
    endgenerate

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[RODBG_CTRL_CORE_EN_BIT] = osc_ctrl_q[RODBG_CTRL_CORE_EN_BIT];
        ctrl_word[RODBG_CTRL_PERIPH_EN_BIT] = osc_ctrl_q[RODBG_CTRL_PERIPH_EN_BIT];
    end

    assign ram_word = {RAM_BYTES[31:RODBG_RAM_LSB], {RODBG_RAM_LSB{1'b0}}};
    assign ssr_word = {{(32 - RODBG_SSR_W){1'b0}}, ssr_q};
    assign thr_word = {{(32 - THREAD_W){1'b0}}, thr_sel_q};
    assign reg_word = {{(32 - RODBG_REGNUM_W){1'b0}}, reg_sel_q};

    always_comb begin
        cause_word = 32'h0000_0000;
        cause_word[RODBG_CAUSE_CODE_LSB +: 3] = cause_q;
        cause_word[RODBG_CAUSE_THREAD_LSB +: THREAD_W] = cause_thr_q;
        cause_word[RODBG_CAUSE_UNIT_LSB +: 2] = cause_unit_q;
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] rd_d;
    logic hit_d;

    always_comb begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (ps_addr)
            RODBG_OFS_OSC_CTRL: rd_d = ctrl_word;
            RODBG_OFS_CORE_CELL: rd_d = count_word[0];
            RODBG_OFS_CORE_WIRE: rd_d = count_word[1];
            RODBG_OFS_PERIPH_CELL: rd_d = count_word[2];
            RODBG_OFS_PERIPH_WIRE: rd_d = count_word[3];
            RODBG_OFS_RAM_SIZE: rd_d = ram_word;
            RODBG_OFS_SAVED_STATUS: rd_d = ssr_word;
            RODBG_OFS_SAVED_PC: rd_d = spc_q;
            RODBG_OFS_SAVED_SP: rd_d = ssp_q;
            RODBG_OFS_THREAD_SEL: rd_d = thr_word;
            RODBG_OFS_REG_SEL: rd_d = reg_word;
            RODBG_OFS_IRQ_CAUSE: rd_d = cause_word;
            RODBG_OFS_IRQ_INFO: rd_d = info_q;
            default: hit_d = 1'b0;
        endcase
    end

    // Registered read data, one cycle after ps_rd
    logic [31:0] rdata_q;
    logic hit_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
            hit_q <= 1'b0;
        end else if (ps_rd) begin
            rdata_q <= rd_d;
            hit_q <= hit_d;
        end
    end

    assign ps_rdata = rdata_q;
    assign ps_hit = hit_q;
endmodule : rodbg_regs

// *** verif/rodbg_regs_chk.sv ***
`timescale 1ns/1ps
module rodbg_regs_chk
    import rodbg_pkg::*;
#(
    parameter logic [31:0] RAM_BYTES = 32'h0008_0000,
    parameter int THREAD_W = RODBG_THREAD_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic ps_wr,
    input wire logic ps_rd,
    input wire logic [7:0] ps_addr,
    input wire logic [31:0] ps_wdata,
    input wire logic [31:0] ps_rdata,
    input wire logic ps_hit,
    // Controls and selectors
    input wire logic core_osc_en,
    input wire logic periph_osc_en,
    input wire logic dbg_enter,
    input wire logic [THREAD_W-1:0] dbg_read_thread,
    input wire logic [RODBG_REGNUM_W-1:0] dbg_read_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic mapped;
    logic wr_ctl;
    assign mapped = ps_addr inside {[8'h06:8'h0A], 8'h0C, [8'h10:8'h16]};
    assign wr_ctl = ps_wr && ps_addr == 8'h06;
    ctrl_write_a: assert property (
        wr_ctl |=> {core_osc_en, periph_osc_en} == $past(ps_wdata[1:0]))
        else $error("osc enables not written");
    ctrl_hold_a: assert property (
        !wr_ctl |=> $stable({core_osc_en, periph_osc_en}))
        else $error("osc enables moved");
    unmapped_read_a: assert property (
        ps_rd && !mapped |=> ps_rdata == 32'h0 && !ps_hit)
        else $error("unmapped read not zero");
    count_upper_a: assert property (
        ps_rd && ps_addr inside {[8'h07:8'h0A]} |=> ps_rdata[31:16] == 16'h0 && ps_hit)
        else $error("count upper bits set");
    ram_size_a: assert property (
        ps_rd && ps_addr == 8'h0C |=> ps_rdata == {RAM_BYTES[31:2], 2'h0})
        else $error("ram size wrong");
    status_res_a: assert property (
        ps_rd && ps_addr == 8'h10 |=> ps_rdata[31:11] == 21'h0 && !ps_rdata[5])
        else $error("status reserved bits set");
    cause_res_a: assert property (
        ps_rd && ps_addr == 8'h15 |=> ps_rdata[31:18] == 14'h0 && ps_rdata[7:3] == 5'h0)
        else $error("cause reserved bits set");
    thread_sel_a: assert property (
        ps_wr && ps_addr == 8'h13 |=> dbg_read_thread == $past(ps_wdata[THREAD_W-1:0]))
        else $error("thread selector wrong");
    reg_sel_a: assert property (
        ps_wr && ps_addr == 8'h14 |=> dbg_read_reg == $past(ps_wdata[4:0]))
        else $error("register selector wrong");
    cover property (ps_rd && ps_addr == 8'h07);
    cover property (dbg_enter);
    cover property (wr_ctl);
    cover property (dbg_enter && ps_wr);
endmodule : rodbg_regs_chk

bind rodbg_regs rodbg_regs_chk #(.RAM_BYTES(RAM_BYTES), .THREAD_W(THREAD_W)) u_rodbg_regs_chk (
    .core_clk, .rst, .ps_wr, .ps_rd, .ps_addr, .ps_wdata, .ps_rdata, .ps_hit,
    .core_osc_en, .periph_osc_en, .dbg_enter, .dbg_read_thread, .dbg_read_reg);

// *** verif/test_rodbg_regs.sv ***
`timescale 1ns/1ps
module test_rodbg_regs;
    import rodbg_pkg::*;
    localparam logic [31:0] RAM = 32'h0004_0000;
    logic core_clk, core_osc_en, periph_osc_en, ps_hit;
    logic rst = 1'b1, ps_wr = 1'b0, ps_rd = 1'b0, dbg_enter = 1'b0;
    logic [3:0] osc = 4'h0, dbg_unit_hits = 4'h0;
    logic [7:0] ps_addr = 8'h0, dbg_thread = 8'h0, dbg_read_thread;
    logic [31:0] ps_wdata = 32'h0, dbg_pc = 32'h0, dbg_sp = 32'h0, dbg_info = 32'h0;
    logic [31:0] ps_rdata, r, e, info;
    logic [10:0] dbg_status_word = 11'h0;
    logic [2:0] dbg_cause = 3'h0;
    logic [4:0] dbg_read_reg;
    logic [15:0] cnt_exp [4];
    int mismatches, cmp_count;
    rodbg_regs #(.RAM_BYTES(RAM)) u_rodbg_regs (
        .core_clk, .rst, .core_cell_osc_clk(osc[0]), .core_wire_osc_clk(osc[1]),
        .periph_cell_osc_clk(osc[2]), .periph_wire_osc_clk(osc[3]), .core_osc_en, .periph_osc_en,
        .ps_wr, .ps_rd, .ps_addr, .ps_wdata, .ps_rdata, .ps_hit, .dbg_enter, .dbg_status_word,
        .dbg_pc, .dbg_sp, .dbg_cause, .dbg_thread, .dbg_unit_hits, .dbg_info, .dbg_read_thread,
        .dbg_read_reg);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        ps_wr <= 1'b1;
        ps_addr <= a;
        ps_wdata <= d;
        @(posedge core_clk);
        ps_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        ps_rd <= 1'b1;
        ps_addr <= a;
        @(posedge core_clk);
        ps_rd <= 1'b0;
        #1;
        r = ps_rdata;
    endtask : rd
    // Oscillator edges are spaced off the core period on purpose
    task automatic osc_step(input logic [1:0] en, input int n);
        wr(8'h06, {30'h0, en});
        repeat (n) begin
            #3 osc = 4'hF;
            #3 osc = 4'h0;
        end
        wr(8'h06, 32'h0);
        repeat (RODBG_STOP_SETTLE_CYC) @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            if (en[1 - i / 2]) cnt_exp[i] += 16'(n);
            rd(8'h07 + 8'(i));
            chk(r, {16'h0, cnt_exp[i]});
        end
    endtask : osc_step
    task automatic t_osc();
        rd(8'h06);
        chk(r, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(8'h07 + 8'(i));
            chk(r, 32'h0);
            cnt_exp[i] = 16'h0;
        end
        wr(8'h06, 32'hFFFF_FFFE);
        #1;
        chk({30'h0, core_osc_en, periph_osc_en}, 32'h2);
        rd(8'h06);
        chk(r, 32'h2);
        osc_step(2'h2, 5);
        osc_step(2'h1, 3);
        osc_step(2'h3, 7);
        $display("test osc done");
    endtask : t_osc
    task automatic t_keep();
        wr(8'h06, 32'h3);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h06);
        chk(r, 32'h0);
        wr(8'h07, 32'hFFFF_FFFF);
        osc_step(2'h0, 4);
        $display("test keep done");
    endtask : t_keep
    task automatic t_ram();
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C);
        chk(r, {RAM[31:2], 2'h0});
        chk({31'h0, ps_hit}, 32'h1);
        rd(8'h0B);
        chk(r, 32'h0);
        chk({31'h0, ps_hit}, 32'h0);
        $display("test ram done");
    endtask : t_ram
    task automatic t_dbg();
        info = 32'h0;
        for (int c = 1; c <= 5; c++) begin
            @(posedge core_clk);
            dbg_enter <= 1'b1;
            dbg_cause <= 3'(c);
            dbg_thread <= 8'h40 + 8'(c);
            dbg_unit_hits <= 4'h6;
            dbg_info <= 32'hA000_0000 + 32'(c);
            dbg_status_word <= 11'h7FF;
            dbg_pc <= 32'hDEAD_BEE0;
            dbg_sp <= 32'h0001_FFF8;
            @(posedge core_clk);
            dbg_enter <= 1'b0;
            e = 32'(c);
            if (c != 1) e[15:8] = 8'h40 + 8'(c);
            if (c >= 3) e[17:16] = 2'h1;
            if (c >= 4) info = 32'hA000_0000 + 32'(c);
            rd(8'h15);
            chk(r, e);
            rd(8'h16);
            chk(r, info);
        end
        rd(8'h10);
        chk(r, 32'h7DF);
        rd(8'h11);
        chk(r, 32'hDEAD_BEE0);
        rd(8'h12);
        chk(r, 32'h0001_FFF8);
        wr(8'h10, 32'h0);
        rd(8'h10);
        chk(r, 32'h100);
        wr(8'h15, 32'hFFFF_FFFF);
        rd(8'h15);
        chk(r, 32'h0003_FF07);
        // Capture and software write in one cycle: capture wins
        @(posedge core_clk);
        dbg_enter <= 1'b1;
        dbg_cause <= 3'h2;
        dbg_thread <= 8'h11;
        dbg_pc <= 32'h0000_1234;
        ps_wr <= 1'b1;
        ps_addr <= 8'h11;
        ps_wdata <= 32'h5555_AAAA;
        @(posedge core_clk);
        dbg_enter <= 1'b0;
        ps_wr <= 1'b0;
        rd(8'h11);
        chk(r, 32'h0000_1234);
        rd(8'h15);
        chk(r, 32'h0000_1102);
        wr(8'h11, 32'h5555_AAAA);
        rd(8'h11);
        chk(r, 32'h5555_AAAA);
        $display("test debug done");
    endtask : t_dbg
    task automatic t_sel();
        wr(8'h13, 32'hFFFF_FFFF);
        rd(8'h13);
        chk(r, {24'h0, dbg_read_thread});
        chk(r, 32'hFF);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14);
        chk(r, {27'h0, dbg_read_reg});
        chk(r, 32'h1F);
        $display("test select done");
    endtask : t_sel
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_osc();
        t_keep();
        t_ram();
        t_dbg();
        t_sel();
        stop_test();
    end
endmodule : test_rodbg_regs
